/* File: verilog/frds_pkg.sv */
`default_nettype none
package frds_pkg;
    localparam int unsigned FRDS_CLK_HZ = 40_000_000;
    localparam int unsigned FRDS_CYC_PER_MS = FRDS_CLK_HZ / 1000;
    localparam logic [7:0] FRDS_CFG_RESET = 8'h00;
    localparam int unsigned FRDS_RESP_LSB = 6;
    localparam int unsigned FRDS_RETRY_LSB = 3;
    localparam int unsigned FRDS_DELAY_LSB = 0;
    localparam logic [2:0] FRDS_RETRY_INF = 3'h7;
    localparam int unsigned FRDS_DLY1_BASE_MS = 10;
    // second delay table in ms, indexed by delay code
    localparam int unsigned FRDS_DLY2_MS [8] = '{252, 558, 924, 1260, 1596, 1932, 2268, 2604};

    typedef enum logic [1:0] {
        FRDS_RESP_IGNORE = 2'h0,
        FRDS_RESP_DELAY = 2'h1,
        FRDS_RESP_SHUT = 2'h2,
        FRDS_RESP_WAIT = 2'h3
    } frds_resp_t;

    // output_overvoltage_fault_response layout
    typedef struct packed {
        frds_resp_t resp;
        logic [2:0] retry;
        logic [2:0] delay;
    } frds_cfg_t;

    // gray coded along run -> pending -> off -> lock
    typedef enum logic [1:0] {
        FRDS_RUN = 2'b00,
        FRDS_PEND = 2'b01,
        FRDS_OFF = 2'b11,
        FRDS_LOCK = 2'b10
    } frds_state_t;
endpackage
`default_nettype wire

/* File: verilog/frds_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module frds_seq #(
    parameter int unsigned CYC_PER_MS = frds_pkg::FRDS_CYC_PER_MS  // clock cycles per millisecond
) (
    input wire logic mclk,                      // system clock, 40 MHz
    input wire logic sys_rst,                   // synchronous reset, active high
    input wire frds_pkg::frds_cfg_t cfg,        // output_overvoltage_fault_response value
    input wire logic fault_det,                 // overvoltage fault from monitor
    output logic out_en,                        // power stage enable
    output logic latched_off,                   // retries exhausted, held off
    output frds_pkg::frds_state_t state         // sequencer state
);
    import frds_pkg::*;

    frds_state_t st_q, st_d;
    logic [31:0] tmr_q, tmr_d;
    logic [2:0] left_q, left_d;
    logic en_q, lat_q;

    // delay lengths in cycles; first delay doubles per code step
    // first delay
    wire [31:0] dly1_cyc = 32'(FRDS_DLY1_BASE_MS * CYC_PER_MS) << cfg.delay;
    wire [31:0] dly2_cyc = 32'(FRDS_DLY2_MS[cfg.delay] * CYC_PER_MS);
    // the timer is a plain down counter; done one cycle early so the
    // transition lands on the edge that completes the programmed length
    // limitation: a delay code written mid-sequence only applies at the next load
    wire tmr_done = (tmr_q <= 32'h0000_0001);
    wire unlimited = (cfg.retry == FRDS_RETRY_INF);
    wire retry_ok = unlimited || (left_q != 3'h0);

    // next-state logic; timer counts down in every state until it reaches zero
    always_comb begin
        st_d = st_q;
        tmr_d = (tmr_q != 32'h0000_0000) ? tmr_q - 32'h0000_0001 : tmr_q;
        left_d = left_q;
        case (st_q)
            FRDS_RUN: begin
                if (fault_det) begin
                    case (cfg.resp)
                        FRDS_RESP_DELAY: begin
                            st_d = FRDS_PEND;
                            tmr_d = dly1_cyc;
                        end
                        FRDS_RESP_SHUT: begin
                            st_d = FRDS_OFF;
                            tmr_d = dly2_cyc;
                        end
                        FRDS_RESP_WAIT: begin
                            st_d = FRDS_OFF;
                            tmr_d = 32'h0000_0000;
                        end
                        default: st_d = FRDS_RUN;
                    endcase
                end
            end
            FRDS_PEND: begin
                if (!fault_det) begin
                    st_d = FRDS_RUN;
                end else if (tmr_done) begin
                    st_d = FRDS_OFF;
                    tmr_d = dly2_cyc;
                end
            end
            FRDS_OFF: begin
                if (cfg.resp == FRDS_RESP_WAIT) begin
                    if (!fault_det) begin
                        st_d = FRDS_RUN;
                    end
                end else if (tmr_done) begin
                    if (!fault_det) begin
                        st_d = FRDS_RUN;
                        left_d = cfg.retry;
                    end else if (retry_ok) begin
                        // attempt while fault present; counts one unless retry is unlimited
                        tmr_d = dly2_cyc;
                        if (!unlimited) begin
                            left_d = left_q - 3'h1;
                        end
                    end else begin
                        st_d = FRDS_LOCK;
                    end
                end
            end
            FRDS_LOCK: st_d = FRDS_LOCK;  // only reset leaves, per latch semantics
            default: st_d = FRDS_RUN;
        endcase
    end

    // reset clears latched fault
    // the enable is registered from the next state so the power stage sees a
    // glitch-free level; the price is that it trails the state by nothing, not a cycle
    // the idle reload keeps a fresh fault from inheriting a spent retry count
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= FRDS_RUN;
            tmr_q <= 32'h0000_0000;
            left_q <= 3'h0;
            en_q <= 1'b0;
            lat_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            left_q <= (st_q == FRDS_RUN && st_d == FRDS_RUN) ? cfg.retry : left_d;
            en_q <= (st_d == FRDS_RUN) || (st_d == FRDS_PEND);
            lat_q <= (st_d == FRDS_LOCK);
        end
    end

    assign out_en = en_q;
    assign latched_off = lat_q;
    assign state = st_q;

    lock_holds_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_LOCK) |=> (st_q == FRDS_LOCK) && !out_en) else $error("latched off left");
    // shutdown mode disables in one cycle
    shut_fast_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_RUN && fault_det && cfg.resp == FRDS_RESP_SHUT) |=> !out_en) else $error("no shutdown");
    ignore_run_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_RUN && cfg.resp == FRDS_RESP_IGNORE) |=> st_q == FRDS_RUN) else $error("ignore acted");
    wait_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_OFF && cfg.resp == FRDS_RESP_WAIT && !fault_det) |=> out_en) else $error("no reenable");
    pend_on_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_PEND) |-> out_en) else $error("off in first delay");
    unlim_nolock_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_OFF && cfg.retry == FRDS_RETRY_INF && cfg.resp != FRDS_RESP_WAIT) |=> st_q != FRDS_LOCK)
        else $error("unlimited latched");
    off_low_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_OFF) |=> !out_en || st_q == FRDS_RUN) else $error("on while off");
    reload_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_OFF && st_d == FRDS_RUN && cfg.resp != FRDS_RESP_WAIT) |=> left_q == $past(cfg.retry))
        else $error("no reload");

    // cycles since the last timer load; restarted by a state change or by tmr_done, so the spacing checks still use the timer
    // for their trigger: a wrong load value shows up as a length mismatch, a stuck decrement never raises tmr_done
    logic [31:0] gap_q;
    wire gap_restart = (st_d != st_q) || tmr_done;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gap_q <= 32'h0000_0000;
        end else begin
            gap_q <= gap_restart ? 32'h0000_0000 : gap_q + 32'h0000_0001;
        end
    end

    spacing_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_OFF && cfg.resp != FRDS_RESP_WAIT && tmr_done) |-> gap_q == dly2_cyc - 32'h0000_0001)
        else $error("attempt spacing wrong");
    dly1_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_PEND && fault_det && tmr_done) |-> gap_q == dly1_cyc - 32'h0000_0001)
        else $error("first delay wrong");
    dly1_load_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_RUN && fault_det && cfg.resp == FRDS_RESP_DELAY) |=> st_q == FRDS_PEND && tmr_q == $past(dly1_cyc))
        else $error("first delay not loaded");
    pend_wait_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_PEND && fault_det && !tmr_done) |=> st_q == FRDS_PEND) else $error("left pending early");
    pend_drop_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_PEND && !fault_det) |=> st_q == FRDS_RUN && out_en) else $error("pending not dropped");
    pend_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_PEND && fault_det && tmr_done) |=> st_q == FRDS_OFF && tmr_q == $past(dly2_cyc))
        else $error("spacing not loaded");
    shut_load_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_RUN && fault_det && cfg.resp == FRDS_RESP_SHUT) |=> tmr_q == $past(dly2_cyc))
        else $error("shutdown spacing wrong");
    shut_state_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_RUN && fault_det && cfg.resp == FRDS_RESP_SHUT) |=> st_q == FRDS_OFF)
        else $error("shutdown not off");
    off_wait_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_OFF && cfg.resp != FRDS_RESP_WAIT && !tmr_done) |=> st_q == FRDS_OFF)
        else $error("off left early");
    attempt_space_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_OFF && cfg.resp != FRDS_RESP_WAIT && tmr_done && fault_det && retry_ok)
        |=> st_q == FRDS_OFF && tmr_q == $past(dly2_cyc)) else $error("attempt not spaced");
    retry_count_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_OFF && cfg.resp != FRDS_RESP_WAIT && tmr_done && fault_det && retry_ok && !unlimited)
        |=> left_q == $past(left_q) - 3'h1) else $error("retry not counted");
    lock_entry_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(st_q == FRDS_LOCK) |-> $past(fault_det) && $past(left_q) == 3'h0 && !$past(unlimited))
        else $error("locked too soon");
    lock_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_LOCK) |-> latched_off) else $error("lock flag low");
    wait_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_OFF && cfg.resp == FRDS_RESP_WAIT && fault_det) |=> st_q == FRDS_OFF && !out_en)
        else $error("wait mode released");
    idle_reload_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_q == FRDS_RUN && st_d == FRDS_RUN) |=> left_q == $past(cfg.retry)) else $error("idle no reload");
    rst_clear_a: assert property (@(posedge mclk)
        sys_rst |=> st_q == FRDS_RUN && !latched_off && !out_en) else $error("reset not cleared");
endmodule // frds_seq
`default_nettype wire

/* File: verification/frds_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
module frds_stage_model (
    input wire logic mclk, // system clock
    input wire logic ov_req, // bench asks for overshoot
    output logic fault_det // monitor flag to sequencer
);
    // comparator output is registered, so the flag lags by a cycle
    always_ff @(posedge mclk) begin
        fault_det <= ov_req;
    end
endmodule // frds_stage_model
`default_nettype wire

/* File: verification/fault_retry_delay_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fault_retry_delay_sequencer_tb;
    import frds_pkg::*;
    localparam int CPM = 4;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic ov_req = 1'b0;
    logic fault_det, out_en, latched_off;
    frds_cfg_t cfg = FRDS_CFG_RESET;
    frds_state_t state;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed = 72;
    int d;
    always #12.5 mclk = ~mclk;
    frds_seq #(.CYC_PER_MS(CPM)) u_dut (.mclk(mclk), .sys_rst(sys_rst), .cfg(cfg), .fault_det(fault_det),
        .out_en(out_en), .latched_off(latched_off), .state(state));
    frds_stage_model u_stage (.mclk(mclk), .ov_req(ov_req), .fault_det(fault_det));
    // model delays in cycles, four cycles per ms so runs stay brief
    function automatic int dly1(input int c);
        return (FRDS_DLY1_BASE_MS << c) * CPM;
    endfunction
    function automatic int dly2(input int c);
        return FRDS_DLY2_MS[c] * CPM;
    endfunction
    task automatic check(input string what, input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // reset, program the response, then raise the overshoot
    task automatic start(input logic [1:0] r, input logic [2:0] rt, input logic [2:0] dl);
        sys_rst = 1'b1;
        ov_req = 1'b0;
        cfg = '{resp: frds_resp_t'(r), retry: rt, delay: dl};
        step(10);
        sys_rst = 1'b0;
        step(4);
        check("lock", latched_off, 1'b0);
        check("en", out_en, 1'b1);
        ov_req = 1'b1;
    endtask
    // hang guard, runs are near 13k cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 40000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        step(2);
        check("en rst", out_en, 1'b0);
        start(2'h0, 3'h0, 3'h0);
        step(100);
        check("en ignore", out_en, 1'b1);
        d = $unsigned($random(seed)) % 2;
        start(2'h1, 3'h0, d[2:0]);
        step(dly1(d) - 2);
        check("en pre d1", out_en, 1'b1);
        step(8);
        check("en post d1", out_en, 1'b0);
        step(dly2(d) + 8);
        check("lock d1", latched_off, 1'b1);
        start(2'h2, 3'h1, 3'h1);
        step(4);
        check("en shut", out_en, 1'b0);
        step(dly2(1));
        check("lock 1st", latched_off, 1'b0);
        step(dly2(1) - 8);
        check("lock gap", latched_off, 1'b0);
        step(12);
        check("lock 2nd", latched_off, 1'b1);
        start(2'h2, 3'h1, 3'h0);
        step(dly2(0) / 2);
        ov_req = 1'b0;
        step(dly2(0));
        check("en back", out_en, 1'b1);
        ov_req = 1'b1;
        step(dly2(0) + 8);
        check("reload", latched_off, 1'b0);
        start(2'h2, 3'h7, 3'h0);
        step(3 * dly2(0));
        check("lock inf", latched_off, 1'b0);
        start(2'h3, 3'h0, 3'h0);
        step(dly2(0) + 8);
        check("en wait", out_en, 1'b0);
        ov_req = 1'b0;
        step(6);
        check("en clear", out_en, 1'b1);
        summarize();
    end
endmodule // fault_retry_delay_sequencer_tb
`default_nettype wire
